// [sysio_pin_select.sv]
// Shared system pin selector: chooses system function or port line
// for the erase and debug pins, tracks the active debug transport and
// gates the async trace onto the test output pin.
// Assumes all inputs synchronous to clk_i and pad settings from the
// port controller that apply in every mode.
// The switch detector samples the test clock, so it must not exceed half of clk_i.
module sysio_pin_select (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Selection word from the matrix special function regs
   input wire logic sel_we_i,
   input wire logic [15:0] sel_wdata_i,
   output logic [15:0] sel_o,
   // Per-line pad settings, lines 4..7 and 12
   input wire sysio_pkg::pad_cfg_type [4:0] pad_cfg_i,
   output sysio_pkg::pad_cfg_type [4:0] pad_cfg_o,
   // Per-line peripheral select and sources
   input wire logic [4:0] periph_sel_i,
   input wire sysio_pkg::pad_drive_type [4:0] soft_drive_i,
   input wire sysio_pkg::pad_drive_type [4:0] periph_drive_i,
   // Pad inputs: erase, tck, tms, tdi, scan select
   input wire logic erase_pin_i,
   input wire logic tck_pin_i,
   input wire logic tms_pin_i,
   input wire logic tdi_pin_i,
   input wire logic boundary_scan_select_i,
   // Debug core side
   input wire logic tdo_core_i,
   input wire logic tdo_core_en_i,
   input wire logic swdio_out_i,
   input wire logic swdio_oe_i,
   input wire logic async_trace_out_i,
   input wire logic trace_en_i,
   // Pad outputs for lines 4..7 and 12
   output sysio_pkg::pad_drive_type [4:0] pad_drive_o,
   // Port line inputs seen by the port controller
   output logic [4:0] port_in_o,
   // System function status
   output logic flash_erase_o,
   output logic boundary_scan_o,
   output logic two_wire_active_o,
   output logic debug_tck_o,
   output logic debug_tms_o,
   output logic debug_tdi_o
);

   // ----------------------------------------------------------------
   // Line index: 0..3 are lines four..seven, 4 is line twelve
   // ----------------------------------------------------------------
   localparam int unsigned LINE_TDI = 0;   // Test in
   localparam int unsigned LINE_TDO = 1;   // Test out or trace out
   localparam int unsigned LINE_TMS = 2;   // Mode select / wire IO
   localparam int unsigned LINE_TCK = 3;   // Test clock / wire clock
   localparam int unsigned LINE_ERS = 4;   // Flash erase

   // Gather the five selection bits into line order
   function automatic logic [4:0] line_sel(input logic [15:0] w);
      line_sel = {w[sysio_pkg::SEL_ERASE_BIT], w[sysio_pkg::SEL_TCK_BIT],
                  w[sysio_pkg::SEL_TMS_BIT], w[sysio_pkg::SEL_TDO_BIT],
                  w[sysio_pkg::SEL_TDI_BIT]};
   endfunction

   // Saturating increment shared by both run counters
   function automatic logic [5:0] sat_inc(input logic [5:0] v);
      sat_inc = (v == sysio_pkg::ONES_MAX) ? v : v + 6'h01;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0] sel_r;                       // Selection word
   logic [15:0] sel_nxt;
   sysio_pkg::transport_type transport_r;    // Active debug transport
   sysio_pkg::transport_type transport_nxt;
   logic [15:0] shift_r;                     // Last 16 mode-select bits
   logic [5:0] ones_r;                       // Run of ones before the code
   logic [5:0] ones_nxt;
   logic armed_r;                            // Code seen after line reset
   logic armed_nxt;
   logic [5:0] tail_r;                       // Run of ones after the code
   logic [5:0] tail_nxt;
   logic tck_d_r;                            // Previous test clock level
   sysio_pkg::pad_drive_type [4:0] drive_nxt;
   sysio_pkg::pad_drive_type [4:0] drive_r;
   logic [4:0] port_in_r;
   logic erase_r;
   logic scan_r;
   logic tck_r;
   logic tms_r;
   logic tdi_r;
   sysio_pkg::pad_cfg_type [4:0] cfg_r;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   wire [4:0] port_mode = line_sel(sel_r);   // High: line is a port line
   wire [4:0] pin_in = {erase_pin_i, tck_pin_i, tms_pin_i, 1'b0, tdi_pin_i};
   // Only the selection write may change pin modes
   assign sel_nxt = sel_we_i ? (sel_wdata_i & sysio_pkg::SEL_MASK) : sel_r;
   // Sample mode select on a rising test clock while debug owns the pins
   wire debug_pins = ~port_mode[LINE_TCK] & ~port_mode[LINE_TMS];
   wire tck_rise = debug_pins & tck_pin_i & ~tck_d_r;
   // Window of the last 16 bits; the oldest bit leaves at bit 0
   wire [15:0] shift_nxt = {tms_pin_i, shift_r[15:1]};
   // Count the ones that leave the window: the code holds zeros of its
   // own, so the leading line reset only shows once it is behind the code
   assign ones_nxt = !tck_rise ? ones_r : !shift_r[0] ? 6'h00 : sat_inc(ones_r);
   wire code_hit = tck_rise && (shift_nxt == sysio_pkg::SWITCH_CODE) &&
                   (ones_nxt >= 6'(sysio_pkg::LINE_RESET_LEN));
   // Ones on the line after the code; restarts on any zero
   assign tail_nxt = !tck_rise ? tail_r : (code_hit || !tms_pin_i) ? 6'h00 : sat_inc(tail_r);
   // Code must be followed by a full line reset before switching
   assign armed_nxt = !tck_rise ? armed_r : (code_hit | (armed_r & tms_pin_i));
   // One bit wider so the closing count cannot wrap to zero
   wire [6:0] tail_inc = {1'b0, tail_r} + 7'h01;
   wire switch_done = tck_rise && armed_r && tms_pin_i &&
                      (tail_inc >= 7'(sysio_pkg::LINE_RESET_LEN));
   assign transport_nxt = switch_done ? sysio_pkg::TRANSPORT_TWO_WIRE : transport_r;
   wire two_wire = (transport_r == sysio_pkg::TRANSPORT_TWO_WIRE);

   // Pad drive per line
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         // Port line: peripheral or software source as selected
         drive_nxt[i] = periph_sel_i[i] ? periph_drive_i[i] : soft_drive_i[i];
         if (!port_mode[i]) begin
            // System functions: inputs do not drive
            drive_nxt[i] = '0;
         end
      end
      if (!port_mode[LINE_TDO]) begin
         // Trace only under two-wire; scan-style drives test data out
         drive_nxt[LINE_TDO].data = two_wire ? async_trace_out_i : tdo_core_i;
         drive_nxt[LINE_TDO].oe = two_wire ? trace_en_i : tdo_core_en_i;
      end
      if (!port_mode[LINE_TMS] && two_wire) begin
         // Wire IO is bidirectional in two-wire mode
         drive_nxt[LINE_TMS].data = swdio_out_i;
         drive_nxt[LINE_TMS].oe = swdio_oe_i;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Selection word: reset to system functions, write applies next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_r <= sysio_pkg::SEL_RESET;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // A probe clock faster than half of clk_i would lose rising edges;
   // the trade buys a single clock domain with no synchroniser
   // Transport tracker and switch sequence detector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         transport_r <= sysio_pkg::TRANSPORT_SCAN;
         shift_r <= 16'h0000;
         ones_r <= 6'h00;
         armed_r <= 1'b0;
         tail_r <= 6'h00;
         tck_d_r <= 1'b0;
      end else begin
         transport_r <= transport_nxt;
         shift_r <= tck_rise ? shift_nxt : shift_r;
         ones_r <= ones_nxt;
         tail_r <= tail_nxt;
         armed_r <= armed_nxt;
         tck_d_r <= tck_pin_i;
      end
   end

   // Pad drive, port inputs and system function inputs
   // Registered so that every pad-facing output comes from a flip-flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_r <= '0;
         port_in_r <= 5'h00;
         erase_r <= 1'b0;
         scan_r <= 1'b0;
         tck_r <= 1'b0;
         tms_r <= 1'b0;
         tdi_r <= 1'b0;
         cfg_r <= '0;
      end else begin
         drive_r <= drive_nxt;
         // Port controller sees the line only in port mode
         port_in_r <= pin_in & port_mode;
         // Erase only while the pin holds its system function
         erase_r <= erase_pin_i & ~port_mode[LINE_ERS];
         scan_r <= boundary_scan_select_i;
         tck_r <= tck_pin_i & ~port_mode[LINE_TCK];
         tms_r <= tms_pin_i & ~port_mode[LINE_TMS];
         tdi_r <= tdi_pin_i & ~port_mode[LINE_TDI] & ~two_wire;
         // Pad settings pass regardless of mode
         cfg_r <= pad_cfg_i;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Straight copies of the registers above
   assign sel_o = sel_r;
   assign pad_drive_o = drive_r;
   assign port_in_o = port_in_r;
   assign flash_erase_o = erase_r;
   assign boundary_scan_o = scan_r;
   assign two_wire_active_o = two_wire;
   assign debug_tck_o = tck_r;
   assign debug_tms_o = tms_r;
   assign debug_tdi_o = tdi_r;
   assign pad_cfg_o = cfg_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Reset and start-up
   reset_defaults_a: assert property (@(posedge clk_i)
      !rst_i && $past(rst_i) |-> sel_r == 16'h0000 && transport_r == sysio_pkg::TRANSPORT_SCAN)
      else $error("State not default after reset");
   debug_at_start_a: assert property (@(posedge clk_i)
      !rst_i && $past(rst_i) |-> !port_mode[LINE_TCK] && !port_mode[LINE_TMS] && !port_mode[LINE_TDO])
      else $error("Debug pins not in debug mode after reset");

   // Selection word, pass-through, transport and routing
   sel_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_we_i |=> sel_r == ($past(sel_wdata_i) & sysio_pkg::SEL_MASK))
      else $error("Selection write not applied next cycle");
   sel_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !sel_we_i |=> $stable(sel_r))
      else $error("Selection changed without a write");
   scan_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      boundary_scan_select_i |=> boundary_scan_o)
      else $error("Scan select not followed");
   transport_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
      two_wire |=> two_wire)
      else $error("Transport left two-wire without reset");
   switch_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(two_wire) |-> $past(armed_r) && $past(tck_rise))
      else $error("Two-wire enabled without the sequence");
   trace_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!two_wire && !port_mode[LINE_TDO]) |=> pad_drive_o[LINE_TDO].oe == $past(tdo_core_en_i))
      else $error("Trace drove test out under scan transport");
   pad_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> pad_cfg_o == $past(pad_cfg_i))
      else $error("Pad settings not applied");
   periph_mux_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (port_mode[LINE_ERS] && periph_sel_i[LINE_ERS]) |=> pad_drive_o[LINE_ERS] == $past(periph_drive_i[LINE_ERS]))
      else $error("Peripheral not routed to port line");
   sel_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |-> (sel_o & ~sysio_pkg::SEL_MASK) == 16'h0000)
      else $error("Unimplemented selection bit set");

   // Gating between system functions and port mode
   erase_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      port_mode[LINE_ERS] |=> !flash_erase_o)
      else $error("Erase seen while the line is a port line");
   tck_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      port_mode[LINE_TCK] |=> !debug_tck_o)
      else $error("Test clock reached debug while in port mode");
   tms_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      port_mode[LINE_TMS] |=> !debug_tms_o)
      else $error("Mode select reached debug while in port mode");
   system_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !port_mode[LINE_ERS] |=> !pad_drive_o[LINE_ERS].oe)
      else $error("Erase pin driven in system mode");
   port_in_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (port_in_o & ~$past(port_mode)) == 5'h00)
      else $error("Port input seen on a system line");

   // Transport and trace
   trace_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (two_wire && !port_mode[LINE_TDO]) |=> pad_drive_o[LINE_TDO].data == $past(async_trace_out_i) &&
      pad_drive_o[LINE_TDO].oe == $past(trace_en_i))
      else $error("Trace not driven under two-wire");
   wire_io_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (two_wire && !port_mode[LINE_TMS]) |=> pad_drive_o[LINE_TMS] == {$past(swdio_out_i), $past(swdio_oe_i)})
      else $error("Wire IO not driven under two-wire");
   tdi_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      two_wire |=> !debug_tdi_o)
      else $error("Test in passed under two-wire");
   switch_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(two_wire) |-> $past(tail_inc) == 7'(sysio_pkg::LINE_RESET_LEN))
      else $error("Switch not at the closing line reset");

endmodule

// [sysio_pkg.sv]
// Package for the shared system pin selector: selection bit positions,
// reset values and the per-line pad setting carrier.
// Assumes a single synchronous clock domain and no register bus.
package sysio_pkg;

   // -------------------------------------------------------------
   // Selection bit positions in the system I/O selection word
   // -------------------------------------------------------------
   localparam int unsigned SEL_W = 16;           // Width of the selection word
   localparam int unsigned SEL_ERASE_BIT = 12;   // Flash erase versus port_b_line_twelve
   localparam int unsigned SEL_TCK_BIT = 7;      // Test clock versus port_b_line_seven
   localparam int unsigned SEL_TMS_BIT = 6;      // Mode select versus port_b_line_six
   localparam int unsigned SEL_TDO_BIT = 5;      // Test out versus port_b_line_five
   localparam int unsigned SEL_TDI_BIT = 4;      // Test in versus port_b_line_four
   localparam logic [15:0] SEL_RESET = 16'h0000; // All zero: every pin in system function
   localparam logic [15:0] SEL_MASK = 16'h10F0;  // Implemented selection bits

   // -------------------------------------------------------------
   // Transport switch sequence: 16-bit pattern on mode select,
   // preceded and followed by at least LINE_RESET_LEN ones
   // -------------------------------------------------------------
   localparam logic [15:0] SWITCH_CODE = 16'hE79E;  // Sent LSB first
   localparam int unsigned LINE_RESET_LEN = 50;     // Ones bracketing the code
   localparam logic [5:0] ONES_MAX = 6'h3F;         // Saturating ones count

   // -------------------------------------------------------------
   // Pad settings for one port line
   // -------------------------------------------------------------
   typedef struct packed {
      logic pull_up;         // Pull-up enable
      logic pull_down;       // Pull-down enable
      logic schmitt;         // Schmitt trigger input
      logic open_drain;      // Multi-drive
      logic glitch_filter;   // Glitch filter enable
      logic debounce;        // Debounce enable
      logic change_irq;      // Input change interrupt enable
   } pad_cfg_type;

   // Output side of one line as driven to the pad
   typedef struct packed {
      logic data;            // Level driven
      logic oe;              // High while the line drives
   } pad_drive_type;

   // Debug transports
   typedef enum logic {
      TRANSPORT_SCAN,
      TRANSPORT_TWO_WIRE
   } transport_type;

endpackage

// [sysio_probe.sv]
// Debug probe model: drives the transport switch sequence on the
// clock and mode pins. Assumes the bench clock paces every edge.
module sysio_probe (
   // Clock and control
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic slow_i,
   // Probe pins
   output logic tck_o,
   output logic tms_o,
   output logic done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [127:0] seq; // Ones, code, ones; bit 0 leaves first
   int k; // Bit index
   int h; // Clocks per half period
   // ------------------------------------------------
   // Sequencer
   // ------------------------------------------------
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b0;
      done_o = 1'b0;
      seq = {56'hFFFFFFFFFFFFFF, 16'hE79E, 56'hFFFFFFFFFFFFFF};
      forever begin
         @(posedge clk_i);
         if (start_i) begin
            done_o <= 1'b0;
            h = slow_i ? 3 : 1;
            for (k = 0; k < 128; k++) begin
               tms_o <= seq[k];
               tck_o <= 1'b0;
               repeat (h) @(posedge clk_i);
               tck_o <= 1'b1;
               repeat (h) @(posedge clk_i);
            end
            // Clock stands still; released line shows the inverse level
            tck_o <= 1'b0;
            tms_o <= ~seq[127];
            done_o <= 1'b1;
         end
      end
   end
endmodule

// [tb_sysio.sv]
// Testbench for the shared system pin selector.
// Assumes one 125 MHz clock and the probe model on the debug pins.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {string name; logic [71:0] val; logic [71:0] msk;} note_type;
   note_type q[$]; // Expected results, oldest first
   logic clk_i = 1'b0, rst_i = 1'b1, sel_we_i = 1'b0, chk_r = 1'b0, start_r = 1'b0, slow_r = 1'b0;
   logic [15:0] sel_wdata_i = 16'h0000, sel_o;
   sysio_pkg::pad_cfg_type [4:0] pad_cfg_i = '0, pad_cfg_o;
   sysio_pkg::pad_drive_type [4:0] soft_drive_i = '0, periph_drive_i = '0, pad_drive_o;
   logic [4:0] periph_sel_i = 5'h00, port_in_o;
   logic erase_pin_i = 1'b0, tdi_pin_i = 1'b0, boundary_scan_select_i = 1'b0, tck_pin_i, tms_pin_i, done;
   logic tdo_core_i = 1'b0, tdo_core_en_i = 1'b0, swdio_out_i = 1'b0, swdio_oe_i = 1'b0;
   logic async_trace_out_i = 1'b0, trace_en_i = 1'b0, flash_erase_o, boundary_scan_o;
   logic two_wire_active_o, debug_tck_o, debug_tms_o, debug_tdi_o;
   int mismatches = 0, cmp_count = 0, cyc = 0, k, p;
   wire logic [71:0] obs = {sel_o, pad_drive_o, port_in_o, flash_erase_o, boundary_scan_o,
      two_wire_active_o, debug_tck_o, debug_tms_o, debug_tdi_o, pad_cfg_o};
   always #4 clk_i = ~clk_i;
   sysio_pin_select uut (.clk_i, .rst_i, .sel_we_i, .sel_wdata_i, .sel_o, .pad_cfg_i, .pad_cfg_o,
      .periph_sel_i, .soft_drive_i, .periph_drive_i, .erase_pin_i, .tck_pin_i, .tms_pin_i,
      .tdi_pin_i, .boundary_scan_select_i, .tdo_core_i, .tdo_core_en_i, .swdio_out_i, .swdio_oe_i,
      .async_trace_out_i, .trace_en_i, .pad_drive_o, .port_in_o, .flash_erase_o, .boundary_scan_o,
      .two_wire_active_o, .debug_tck_o, .debug_tms_o, .debug_tdi_o);
   sysio_probe probe (.clk_i, .start_i(start_r), .slow_i(slow_r), .tck_o(tck_pin_i),
      .tms_o(tms_pin_i), .done_o(done));
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Note an expectation; the watcher samples at the next edge
   task automatic note_obs(input string nm, input logic [71:0] v, input logic [71:0] m);
      q.push_back('{nm, v, m});
      chk_r <= 1'b1;
      tick(1);
      chk_r <= 1'b0;
   endtask
   // Random pad settings and sources; enables given, then settle
   task automatic rnd(input logic [1:0] en);
      pad_cfg_i <= 35'({$urandom(), $urandom()});
      soft_drive_i <= 10'($urandom());
      periph_drive_i <= 10'($urandom());
      periph_sel_i <= 5'($urandom());
      {erase_pin_i, tdi_pin_i, boundary_scan_select_i, tdo_core_i} <= 4'($urandom());
      {swdio_out_i, swdio_oe_i, async_trace_out_i} <= 3'($urandom());
      {tdo_core_en_i, trace_en_i} <= en;
      tick(3);
   endtask
   task automatic wr(input logic [15:0] d);
      sel_we_i <= 1'b1;
      sel_wdata_i <= d;
      tick(1);
      sel_we_i <= 1'b0;
      note_obs("sel", {d & sysio_pkg::SEL_MASK, 56'h0}, {16'hFFFF, 56'h0});
      tick(3);
   endtask
   // System mode with trace wanted and scan test-out off
   task automatic sys_chk(input logic tw);
      rnd(2'b01);
      note_obs("sys", {16'h0000, 4'h0, tw ? {swdio_out_i, swdio_oe_i} : 2'b00,
         tw ? async_trace_out_i : tdo_core_i, tw, 2'b00, 5'h00, erase_pin_i,
         boundary_scan_select_i, tw, tck_pin_i, tms_pin_i, tdi_pin_i & ~tw, pad_cfg_i},
         '1);
   endtask
   function automatic logic [9:0] port_drive();
      logic [9:0] r;
      for (int i = 0; i < 5; i++) begin
         r[2*i +: 2] = periph_sel_i[i] ? periph_drive_i[i] : soft_drive_i[i];
      end
      return r;
   endfunction
   // ------------------------------------------------
   // Watcher and timeout
   // ------------------------------------------------
   always @(posedge clk_i) begin
      note_type n;
      if (chk_r) begin
         n = q.pop_front();
         cmp_count++;
         if ((obs & n.msk) !== (n.val & n.msk)) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n.name, n.val & n.msk, obs & n.msk);
         end
      end
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         summarize();
      end
   end
   // ------------------------------------------------
   // Main sequence: slow probe, then prompt probe
   // ------------------------------------------------
   initial begin
      void'($urandom(24));
      for (p = 0; p < 2; p++) begin
         rst_i <= 1'b1;
         erase_pin_i <= 1'b0;
         slow_r <= (p == 0);
         tick(p == 0 ? 12 : 2);
         rst_i <= 1'b0;
         sys_chk(1'b0);
         start_r <= 1'b1;
         tick(1);
         start_r <= 1'b0;
         tick(2);
         for (k = 0; k < 2000 && !done; k++) begin
            tick(1);
         end
         sys_chk(1'b1);
         wr(16'($urandom()));
         wr(16'hFFFF);
         rnd(2'($urandom()));
         note_obs("port", {sysio_pkg::SEL_MASK, port_drive(), erase_pin_i, tck_pin_i, tms_pin_i, 1'b0,
            tdi_pin_i, 1'b0, boundary_scan_select_i, 1'b1, 3'b000, pad_cfg_i}, '1);
         $display("pass %0d done", p);
      end
      summarize();
   end
endmodule
